// ---- design/maips_bus_cycle.sv ----
`timescale 1ns/1ps
`include "maips_cfg.svh"
module maips_bus_cycle
    import maips_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       clkEn,
    // Request.
    input  wire logic       start,
    output logic            busy,
    output logic            done
);
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic       next_done;

    always_comb begin
        next_cnt  = cnt;
        next_done = 1'b0;
        if (cnt != `MAIPS_ZERO4) begin
            next_cnt = cnt - `MAIPS_ONE4;
            if (cnt == `MAIPS_ONE4) begin
                next_done = 1'b1;
            end
        end else if (start) begin
            next_cnt = `MAIPS_RD_CYCLES;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt  <= `MAIPS_ZERO4;
            done <= 1'b0;
        end else if (clkEn) begin
            cnt  <= next_cnt;
            done <= next_done;
        end
    end

    assign busy = (cnt != `MAIPS_ZERO4);
endmodule

// ---- design/maips_cfg.svh ----
`ifndef MAIPS_CFG_SVH
`define MAIPS_CFG_SVH
`define MAIPS_NUM_CONV      7
`define MAIPS_PORT_STATUS   8'h00
`define MAIPS_PORT_CONV1    8'h01
`define MAIPS_MEM_BASE      16'h3e00
`define MAIPS_ADDR_STEP     16'h0001
`define MAIPS_ZERO3         3'h0
`define MAIPS_ONE3          3'h1
`define MAIPS_LAST3         3'h7
`define MAIPS_RD_CYCLES     4'h4
`define MAIPS_ONE4          4'h1
`define MAIPS_ZERO4         4'h0
`define MAIPS_ID_PAD        5'h00
`define MAIPS_STATUS_IDLE   8'hff
`define MAIPS_ADDR_IDLE     8'hff
`define MAIPS_ZERO8         8'h00
`define MAIPS_ZERO16        16'h0000
`endif

// ---- design/maips_host.sv ----
`timescale 1ns/1ps
`include "maips_cfg.svh"
module maips_host
    import maips_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clkEn,
    // Shared interrupt, active low.
    input  wire logic        irqN,
    output logic             irqAck,
    // Inverted peripheral I/O bus.
    output logic [7:0]       ioAddrN,
    output logic             ioRdN,
    input  wire logic [7:0]  ioDataN,
    // Memory write port.
    output logic [15:0]      memAddr,
    output logic [7:0]       memData,
    output logic             memWe,
    // Status.
    output logic             busy
);
    maips_state_t state;
    maips_state_t next_state;
    logic [7:0]   status;
    logic [7:0]   next_status;
    logic [2:0]   conv;
    logic [2:0]   next_conv;
    logic [7:0]   data;
    logic [7:0]   next_data;
    logic [15:0]  ptr;
    logic [15:0]  next_ptr;
    logic [7:0]   cycPort;
    logic [7:0]   next_ioAddrN;
    logic         next_ioRdN;
    logic [15:0]  next_memAddr;
    logic [7:0]   next_memData;
    logic         next_memWe;
    logic [2:0]   first;
    logic         cycStart;
    logic         cycBusy;
    logic         cycDone;

    // Lowest-numbered requesting converter, or zero when none is pending.
    function automatic logic [2:0] pick_first(input logic [7:0] st);
        logic [2:0] r;
        r = `MAIPS_ZERO3;
        for (int i = `MAIPS_NUM_CONV; i >= 1; i--) begin
            if (!st[i-1]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // I/O port of a converter; converter one sits just above the status latch.
    function automatic logic [7:0] conv_port(input logic [2:0] c);
        return `MAIPS_PORT_CONV1 + {`MAIPS_ID_PAD, 3'(c - `MAIPS_ONE3)};
    endfunction

    // Identifier byte stored after each data byte.
    function automatic logic [7:0] id_word(input logic [2:0] c);
        return {`MAIPS_ID_PAD, c};
    endfunction

    // Status word with a served converter marked as no longer pending.
    function automatic logic [7:0] mark_served(input logic [7:0] st, input logic [2:0] c);
        logic [7:0] r;
        r = st;
        r[c - `MAIPS_ONE3] = 1'b1;
        return r;
    endfunction

    assign first = pick_first(status);

    maips_bus_cycle maips_bus_cycle_inst (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clkEn   (clkEn),
        .start   (cycStart),
        .busy    (cycBusy),
        .done    (cycDone)
    );

    // Service sequence: status read, then a data read and two stores per converter.
    always_comb begin
        next_state  = state;
        next_status = status;
        next_conv   = conv;
        next_data   = data;
        next_ptr    = ptr;
        cycPort     = `MAIPS_PORT_STATUS;
        cycStart    = 1'b0;
        unique case (state)
            S_IDLE: begin
                if (!irqN) begin
                    next_state = S_STATRD;
                    cycPort    = `MAIPS_PORT_STATUS;
                    cycStart   = 1'b1;
                end
            end
            S_STATRD: begin
                if (cycDone) begin
                    next_status = ~ioDataN;
                    next_state  = S_PICK;
                end
            end
            S_PICK: begin
                next_conv = first;
                if (first == `MAIPS_ZERO3) begin
                    next_state = S_DONE;
                end else begin
                    cycPort    = conv_port(first);
                    cycStart   = 1'b1;
                    next_state = S_DATARD;
                end
            end
            S_DATARD: begin
                if (cycDone) begin
                    next_data   = ~ioDataN;
                    next_status = mark_served(status, conv);
                    next_state  = S_WRDATA;
                end
            end
            S_WRDATA: begin
                next_ptr   = ptr + `MAIPS_ADDR_STEP;
                next_state = S_WRID;
            end
            S_WRID: begin
                next_ptr   = ptr + `MAIPS_ADDR_STEP;
                next_state = S_PICK;
            end
            S_DONE: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state  <= S_IDLE;
            status <= `MAIPS_STATUS_IDLE;
            conv   <= `MAIPS_ZERO3;
            data   <= `MAIPS_ZERO8;
            ptr    <= `MAIPS_MEM_BASE;
        end else if (clkEn) begin
            state  <= next_state;
            status <= next_status;
            conv   <= next_conv;
            data   <= next_data;
            ptr    <= next_ptr;
        end
    end

    // The read strobe stays low until the cycle counter ends the access.
    always_comb begin
        next_ioAddrN = ioAddrN;
        next_ioRdN   = 1'b1;
        if (cycStart) begin
            next_ioAddrN = ~cycPort;
            next_ioRdN   = 1'b0;
        end else if ((state == S_STATRD || state == S_DATARD) && !cycDone) begin
            next_ioRdN = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ioAddrN <= `MAIPS_ADDR_IDLE;
            ioRdN   <= 1'b1;
        end else if (clkEn) begin
            ioAddrN <= next_ioAddrN;
            ioRdN   <= next_ioRdN;
        end
    end

    // Each data byte is stored first and its identifier at the next address.
    always_comb begin
        next_memAddr = memAddr;
        next_memData = memData;
        next_memWe   = 1'b0;
        if (state == S_WRDATA) begin
            next_memAddr = ptr;
            next_memData = data;
            next_memWe   = 1'b1;
        end else if (state == S_WRID) begin
            next_memAddr = ptr;
            next_memData = id_word(conv);
            next_memWe   = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            memAddr <= `MAIPS_ZERO16;
            memData <= `MAIPS_ZERO8;
            memWe   <= 1'b0;
        end else if (clkEn) begin
            memAddr <= next_memAddr;
            memData <= next_memData;
            memWe   <= next_memWe;
        end
    end

    assign irqAck = (state == S_STATRD) && !cycBusy;
    assign busy   = (state != S_IDLE) || cycBusy;
endmodule

// ---- design/maips_pkg.sv ----
package maips_pkg;
    typedef enum logic [6:0] {
        S_IDLE   = 7'b0000001,
        S_STATRD = 7'b0000010,
        S_PICK   = 7'b0000100,
        S_DATARD = 7'b0001000,
        S_WRDATA = 7'b0010000,
        S_WRID   = 7'b0100000,
        S_DONE   = 7'b1000000
    } maips_state_t;
endpackage

// ---- testbench/maips_adc_model.sv ----
`timescale 1ns/1ps
module maips_adc_model (
    input  wire logic       clk_sys,
    input  wire logic [6:0] req,
    input  wire logic [7:0] ioAddrN,
    input  wire logic       ioRdN,
    output logic            irqN,
    output logic [7:0]      ioDataN
);
    logic [6:0] pend = 7'h0;
    logic       rdQ  = 1'b1;
    logic [7:0] last = 8'h0;
    logic [7:0] port;
    logic [7:0] val;
    logic [7:0] clr;
    assign port = ~ioAddrN;
    assign val = (port == 8'h00) ? {1'b1, ~pend} : 8'h30 + port;
    assign clr = (ioRdN && !rdQ) ? 8'h01 << port : 8'h00;
    assign irqN = ~|pend;
    assign ioDataN = ioRdN ? ~last : ~val;
    always @(posedge clk_sys) begin
        rdQ <= ioRdN;
        if (!ioRdN) last <= ~val;
        pend <= (pend | req) & ~clr[7:1];
    end
endmodule

// ---- testbench/maips_host_assertions.sv ----
`timescale 1ns/1ps
module maips_host_assertions (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        clkEn,
    input wire logic        irqN,
    input wire logic        irqAck,
    input wire logic [7:0]  ioAddrN,
    input wire logic        ioRdN,
    input wire logic [15:0] memAddr,
    input wire logic [7:0]  memData,
    input wire logic        memWe,
    input wire logic        busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst || !clkEn);
    a_ack_status: assert property (irqAck |-> !ioRdN && ioAddrN == 8'hff)
        else $error("ack");
    a_start_irq: assert property (!busy && !irqN |-> ##[1:2] busy)
        else $error("start");
    a_status_first: assert property ($rose(busy) |-> ##[0:2] !ioRdN && ioAddrN == 8'hff)
        else $error("status");
    a_strobe_len: assert property ($fell(ioRdN) |-> !ioRdN [*5] ##1 ioRdN)
        else $error("strobe");
    a_port_range: assert property (!ioRdN |-> ~ioAddrN <= 8'h07)
        else $error("port");
    a_addr_hold: assert property (!ioRdN && !$past(ioRdN) |-> $stable(ioAddrN))
        else $error("addr");
    a_pair_addr: assert property ($rose(memWe) |=> memWe && memAddr == $past(memAddr) + 16'h1)
        else $error("pair");
    a_id_value: assert property ($rose(memWe) |=> memData inside {[8'h01:8'h07]})
        else $error("id");
    a_idle_quiet: assert property (!busy |-> ioRdN && !memWe)
        else $error("idle");
    cover property ($rose(memWe));
    cover property ($fell(ioRdN) && ioAddrN == 8'hf8);
    cover property ($fell(busy));
endmodule

// ---- testbench/maips_host_tb_top.sv ----
`timescale 1ns/1ps
`include "maips_cfg.svh"
module maips_host_tb_top;
    logic        clk_sys = 0;
    logic        rst = 1;
    logic        clkEn = 1;
    logic [6:0]  req = 0;
    logic        irqN, irqAck, ioRdN, memWe, busy;
    logic [7:0]  ioAddrN, ioDataN, memData;
    logic [15:0] memAddr;
    logic [15:0] ptr = `MAIPS_MEM_BASE;
    logic [15:0] wa [0:63];
    logic [7:0]  wd [0:63];
    int          n = 0, k = 0, failures = 0, compares = 0, acks = 0, srv = 0;
    always #25 clk_sys = ~clk_sys;
    maips_host maips_host_inst (.clk_sys, .rst, .clkEn, .irqN, .irqAck, .ioAddrN,
        .ioRdN, .ioDataN, .memAddr, .memData, .memWe, .busy);
    maips_adc_model maips_adc_model_inst (.clk_sys, .req, .ioAddrN, .ioRdN, .irqN, .ioDataN);
    always @(posedge clk_sys) if (irqAck === 1'b1) acks <= acks + 1;
    always @(posedge clk_sys) if (memWe === 1'b1) begin
        wa[n] <= memAddr;
        wd[n] <= memData;
        n <= n + 1;
    end
    task cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task final_report;
        $display("Checks %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task raise(input logic [6:0] m);
        req = m;
        @(negedge clk_sys);
        req = 0;
        @(negedge clk_sys);
    endtask
    task serve(input logic [6:0] m);
        int c;
        for (c = 0; c < 3000; c++) begin
            @(negedge clk_sys);
            if (busy === 1'b0 && irqN === 1'b1 && n >= k + 2 * $countones(m)) break;
        end
        if (c == 3000) begin
            failures++;
            final_report;
        end
        for (int i = 0; i < 7; i++) if (m[i]) begin
            cmp("data addr", ptr, wa[k]);
            cmp("data", 16'(8'h30 + i + 1), 16'(wd[k]));
            cmp("id addr", ptr + 16'h1, wa[k + 1]);
            cmp("id", 16'(i + 1), 16'(wd[k + 1]));
            k += 2;
            ptr += 16'h2;
        end
        cmp("count", 16'(k), 16'(n));
        srv++;
        cmp("ack", 16'(srv), 16'(acks));
    endtask
    task t_freeze;
        logic [7:0] a;
        raise(7'h21);
        repeat (8) @(negedge clk_sys);
        a = ioAddrN;
        clkEn = 0;
        repeat (10) @(negedge clk_sys);
        cmp("frozen addr", 16'(a), 16'(ioAddrN));
        cmp("frozen strobe", 16'h0, 16'(ioRdN));
        cmp("frozen busy", 16'h1, 16'(busy));
        clkEn = 1;
        serve(7'h21);
    endtask
    task t_single;
        raise(7'h08);
        serve(7'h08);
    endtask
    task t_any_order;
        raise(7'h40);
        raise(7'h12);
        serve(7'h52);
    endtask
    task t_all;
        raise(7'h7f);
        serve(7'h7f);
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        cmp("reset addr", 16'h00ff, 16'(ioAddrN));
        cmp("reset we", 16'h0, 16'(memWe));
        rst = 0;
        @(negedge clk_sys);
        t_single;
        t_any_order;
        t_all;
        t_freeze;
        final_report;
    end
endmodule
bind maips_host maips_host_assertions maips_host_assertions_inst (.clk_sys, .rst, .clkEn, .irqN, .irqAck,
    .ioAddrN, .ioRdN, .memAddr, .memData, .memWe, .busy);
